// ===== src/frbg_defines.svh
// constants for the fractional rate divider
`ifndef FRBG_DEFINES_SVH
`define FRBG_DEFINES_SVH
// register select codes on the write port
`define FRBG_SEL_LOW 2'h0
`define FRBG_SEL_HIGH 2'h1
`define FRBG_SEL_FRAC 2'h2
`define FRBG_SEL_NONE 2'h3
// reset values
`define FRBG_LOW_RST 8'h01
`define FRBG_HIGH_RST 8'h00
`define FRBG_FRAC_RST 8'h00
// fields of the fraction and sampling register
`define FRBG_FRAC_MSB 3
`define FRBG_FRAC_LSB 0
`define FRBG_MODE_MSB 5
`define FRBG_MODE_LSB 4
// prescaler enable bit of the modem control register, last prescaler count and divide ratio
`define FRBG_PRESC_BIT 7
`define FRBG_PRESC_LAST 2'h3
`define FRBG_PRESC_DIV 3'h4
// sampling mode encodings and samples per bit
`define FRBG_MODE_16X 2'h0
`define FRBG_MODE_8X 2'h1
`define FRBG_MODE_4X 2'h2
`define FRBG_SPB_16X 5'h10
`define FRBG_SPB_8X 5'h08
`define FRBG_SPB_4X 5'h04
`define FRBG_MODE_SPARE 2'h3
// a zero integer counts as the full range; one fraction window is sixteen periods
`define FRBG_INT_FULL 17'h10000
`define FRBG_FRAC_SPAN 5'h10
// shortest reset pulse
`define FRBG_RST_MIN_NS 40
`define FRBG_CLK_NS 8
`define FRBG_RST_MIN_CYC ((`FRBG_RST_MIN_NS + `FRBG_CLK_NS - 1) / `FRBG_CLK_NS)
`endif

// ===== src/frbg_pkg.sv
// types for the fractional rate divider
package frbg_pkg;
	typedef enum logic [1:0] {
		FRBG_X16,
		FRBG_X8,
		FRBG_X4
	} frbg_mode_e;
	typedef logic [16:0] frbg_len_t;
endpackage : frbg_pkg

// ===== src/frbg_rate_divider.sv
// fractional rate divider with prescaler, one per serial channel
`timescale 1ns/1ps
`default_nettype none
`include "frbg_defines.svh"

// Operation
// - prescaler divides oscillator clock by 1, or by 4 when control bit 7 set
// - divisor from 1 to 65536 plus 15/16 in steps of 1/16
// - one sampling tick drives both transmit shifting and receive sampling
// - after reset low byte is 0x01, high byte and fraction 0x00
// - integer divisor is high byte as 15:8 and low byte as 7:0
// - fraction bits 3:0 give N/16, 0000 zero to 1111 fifteen sixteenths
// - mode bits 5:4: 00 is 16X, 01 is 8X, 10 is 4X
// - bit rate is clock over prescale over divisor over 16, 8 or 4
// - 8X with odd fraction may jitter bit time by 1/16
// - 4X with odd fraction not multiple of 4 may jitter by 1/8
// - each channel owns its own prescaler and divider instance
// - one bit lasts 16, 8 or 4 sampling ticks by mode
// - active low reset restores divisor and mode defaults
module frbg_rate_divider import frbg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// register write port
	input wire logic reg_wr,
	input wire logic [1:0] reg_sel,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] modem_control_reg,
	// register readback
	output logic [7:0] divisor_low_byte,
	output logic [7:0] divisor_high_byte,
	output logic [7:0] divisor_fraction_and_sampling,
	// timing outputs
	output logic sample_tick,
	output logic bit_tick
);

	function automatic frbg_mode_e mode_of(input logic [1:0] f);
		case (f)
			`FRBG_MODE_8X: mode_of = FRBG_X8;
			`FRBG_MODE_4X: mode_of = FRBG_X4;
			// the spare code falls back to 16X
			default: mode_of = FRBG_X16;
		endcase
	endfunction : mode_of

	function automatic logic [4:0] spb_of(input frbg_mode_e m);
		case (m)
			FRBG_X8: spb_of = `FRBG_SPB_8X;
			FRBG_X4: spb_of = `FRBG_SPB_4X;
			default: spb_of = `FRBG_SPB_16X;
		endcase
	endfunction : spb_of

	logic [7:0] low_q, high_q, frac_q;
	logic [1:0] pcnt_q, pcnt_d;
	frbg_len_t dcnt_q, dcnt_d;
	logic [3:0] acc_q, acc_d;
	logic [3:0] bcnt_q, bcnt_d;
	logic tick_q, tick_d, bit_q, bit_d;

	// decode
	wire logic restart = reg_wr;
	wire logic wr_low = reg_wr && (reg_sel == `FRBG_SEL_LOW);
	wire logic wr_high = reg_wr && (reg_sel == `FRBG_SEL_HIGH);
	wire logic wr_frac = reg_wr && (reg_sel == `FRBG_SEL_FRAC);
	wire logic presc = modem_control_reg[`FRBG_PRESC_BIT];
	wire logic [3:0] frac_n = frac_q[`FRBG_FRAC_MSB:`FRBG_FRAC_LSB];
	wire frbg_mode_e mode = mode_of(frac_q[`FRBG_MODE_MSB:`FRBG_MODE_LSB]);
	wire logic [4:0] spb = spb_of(mode);
	wire logic [15:0] div_int = {high_q, low_q};

	// prescaler: one tick per oscillator cycle, or one in four
	wire logic pre_tick = !presc || (pcnt_q == `FRBG_PRESC_LAST);

	// a zero integer counts as 65536 periods
	wire frbg_len_t int_len = (div_int == 16'h0000) ? `FRBG_INT_FULL : {1'b0, div_int};
	// fraction accumulator: carry out stretches this period by one
	wire logic [4:0] acc_sum = {1'b0, acc_q} + {1'b0, frac_n};
	wire logic stretch = acc_sum[4];
	wire frbg_len_t last_cnt = stretch ? int_len : int_len - 17'h00001;
	wire logic eop = pre_tick && (dcnt_q == last_cnt);
	wire logic last_sample = ({1'b0, bcnt_q} == spb - 5'h01);

	// next state
	always_comb begin
		pcnt_d = pcnt_q;
		dcnt_d = dcnt_q;
		acc_d = acc_q;
		bcnt_d = bcnt_q;
		tick_d = 1'b0;
		bit_d = 1'b0;
		if (restart) begin
			// a new rate starts from a clean period
			pcnt_d = 2'h0;
			dcnt_d = '0;
			acc_d = 4'h0;
			bcnt_d = 4'h0;
		end else begin
			pcnt_d = presc ? pcnt_q + 2'h1 : 2'h0;
			if (pre_tick) begin
				dcnt_d = eop ? '0 : dcnt_q + 17'h00001;
			end
			if (eop) begin
				acc_d = acc_sum[3:0];
				tick_d = 1'b1;
				// odd fractions leave stretched periods unevenly placed in a bit
				bcnt_d = last_sample ? 4'h0 : bcnt_q + 4'h1;
				bit_d = last_sample;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			low_q <= `FRBG_LOW_RST;
			high_q <= `FRBG_HIGH_RST;
			frac_q <= `FRBG_FRAC_RST;
		end else begin
			if (wr_low) begin
				low_q <= reg_wdata;
			end
			if (wr_high) begin
				high_q <= reg_wdata;
			end
			if (wr_frac) begin
				frac_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pcnt_q <= 2'h0;
			dcnt_q <= '0;
			acc_q <= 4'h0;
			bcnt_q <= 4'h0;
			tick_q <= 1'b0;
			bit_q <= 1'b0;
		end else begin
			pcnt_q <= pcnt_d;
			dcnt_q <= dcnt_d;
			acc_q <= acc_d;
			bcnt_q <= bcnt_d;
			tick_q <= tick_d;
			bit_q <= bit_d;
		end
	end

	assign divisor_low_byte = low_q;
	assign divisor_high_byte = high_q;
	assign divisor_fraction_and_sampling = frac_q;
	// transmit and receive both take this single tick
	assign sample_tick = tick_q;
	assign bit_tick = bit_q;

	// checking helpers: cycles since last tick, and stretch count over 16 periods
	logic [19:0] gap_q;
	logic gap_ok_q;
	logic [4:0] per_q;
	logic [4:0] ext_q;
	wire logic [19:0] ratio = presc ? 20'(`FRBG_PRESC_DIV) : 20'h00001;
	wire logic [19:0] base_len = ratio * {3'h0, int_len};
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gap_q <= 20'h0;
			gap_ok_q <= 1'b0;
			per_q <= 5'h0;
			ext_q <= 5'h0;
		end else if (restart) begin
			gap_q <= 20'h0;
			gap_ok_q <= 1'b0;
			per_q <= 5'h0;
			ext_q <= 5'h0;
		end else begin
			gap_q <= tick_q ? 20'h1 : gap_q + 20'h1;
			if (tick_q) begin
				gap_ok_q <= 1'b1;
			end
			if (eop) begin
				per_q <= (per_q == `FRBG_FRAC_SPAN) ? 5'h1 : per_q + 5'h1;
				ext_q <= ((per_q == `FRBG_FRAC_SPAN) ? 5'h0 : ext_q) + {4'h0, stretch};
			end
		end
	end

	reset_defaults_a: assert property (@(posedge ref_clk)
		$rose(nrst) |-> low_q == `FRBG_LOW_RST && high_q == `FRBG_HIGH_RST
		&& frac_q == `FRBG_FRAC_RST)
		else $error("divisor defaults wrong after reset");

	presc_four_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(pre_tick && presc && !restart) ##1 (presc && !restart)[*3] |-> !pre_tick ##1 pre_tick)
		else $error("prescaler not dividing by four");

	presc_bypass_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!presc && !restart && !eop) |=> dcnt_q == $past(dcnt_q) + 17'h00001)
		else $error("prescaler not bypassed");

	restart_clears_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		restart |=> dcnt_q == '0 && bcnt_q == 4'h0 && acc_q == 4'h0 && !tick_q)
		else $error("write did not restart divider");

	period_bounds_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tick_q && gap_ok_q && !restart && $stable(presc))
		|-> gap_q >= base_len && gap_q <= base_len + ratio)
		else $error("tick spacing outside divisor range");

	period_exact_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tick_q && gap_ok_q && frac_n == 4'h0 && $stable(presc)) |-> gap_q == base_len)
		else $error("integer divisor period wrong");

	frac_spread_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(eop && !restart && per_q == `FRBG_FRAC_SPAN) |-> ext_q == {1'b0, frac_n})
		else $error("stretched periods do not match fraction");

	bit_on_tick_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		bit_tick |-> sample_tick && $past(bcnt_q) == spb[3:0] - 4'h1)
		else $error("bit end not on last sample");

	x16_len_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(bit_tick && mode == FRBG_X16) |-> $past(bcnt_q) == 4'hf)
		else $error("16X bit not sixteen samples");

	// readback port: a write shows the next cycle, anything else leaves all three alone
	low_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(reg_wr && reg_sel == `FRBG_SEL_LOW) |=> divisor_low_byte == $past(reg_wdata))
		else $error("low byte write did not land");

	high_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(reg_wr && reg_sel == `FRBG_SEL_HIGH) |=> divisor_high_byte == $past(reg_wdata))
		else $error("high byte write did not land");

	frac_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(reg_wr && reg_sel == `FRBG_SEL_FRAC)
		|=> divisor_fraction_and_sampling == $past(reg_wdata))
		else $error("fraction write did not land");

	regs_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!reg_wr || reg_sel == `FRBG_SEL_NONE) |=> $stable(divisor_low_byte)
		&& $stable(divisor_high_byte) && $stable(divisor_fraction_and_sampling))
		else $error("readback changed without a write");

	// counters: each one moves only on its own event, so a stray step shows at once
	presc_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(presc && !restart) |=> pcnt_q == $past(pcnt_q) + 2'h1)
		else $error("prescaler count skipped");

	count_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		dcnt_q <= int_len)
		else $error("divider count ran past its end");

	restart_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		restart |=> !bit_tick && pcnt_q == 2'h0)
		else $error("write left bit or prescaler running");

	acc_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!eop && !restart) |=> $stable(acc_q))
		else $error("fraction accumulator moved between periods");

	// a zero fraction must never inherit a remainder from an earlier rate
	acc_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(eop && !restart && frac_n == 4'h0) |=> acc_q == 4'h0)
		else $error("zero fraction left accumulator set");

	// bit length per mode; the spare code counts as 16X
	x8_len_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(bit_tick && mode == FRBG_X8) |-> $past(bcnt_q) == 4'(`FRBG_SPB_8X - 5'h01))
		else $error("8X bit not eight samples");

	x4_len_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(bit_tick && mode == FRBG_X4) |-> $past(bcnt_q) == 4'(`FRBG_SPB_4X - 5'h01))
		else $error("4X bit not four samples");

	spare_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(bit_tick && frac_q[`FRBG_MODE_MSB:`FRBG_MODE_LSB] == `FRBG_MODE_SPARE)
		|-> $past(bcnt_q) == 4'(`FRBG_SPB_16X - 5'h01))
		else $error("spare mode code not timed as 16X");

	bit_kept_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sample_tick && $past(bcnt_q) == spb[3:0] - 4'h1) |-> bit_tick)
		else $error("bit end missing on last sample");

	bit_single_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		bit_tick |=> !bit_tick)
		else $error("bit tick longer than one cycle");

	tick_release_a: assert property (@(posedge ref_clk)
		$rose(nrst) |-> !sample_tick && !bit_tick)
		else $error("tick seen at reset release");

	cov_frac_16x_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		bit_tick && mode == FRBG_X16 && frac_n != 4'h0);
	cov_odd_8x_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		bit_tick && mode == FRBG_X8 && frac_n[0]);
	cov_presc_4x_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		bit_tick && mode == FRBG_X4 && presc);
	cov_high_byte_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		bit_tick && div_int[15:8] != 8'h00);
	cov_spare_mode_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		bit_tick && frac_q[`FRBG_MODE_MSB:`FRBG_MODE_LSB] == `FRBG_MODE_SPARE);

endmodule : frbg_rate_divider
`default_nettype wire

// ===== bench/fractional_baud_rate_generator_bench.sv
// self-checking bench for the fractional rate divider
`timescale 1ns/1ps
`default_nettype none
module fractional_baud_rate_generator_bench import frbg_pkg::*; ;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic reg_wr = 1'b0;
	logic [1:0] reg_sel = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] modem_control_reg = 8'h00;
	logic [7:0] divisor_low_byte;
	logic [7:0] divisor_high_byte;
	logic [7:0] divisor_fraction_and_sampling;
	logic sample_tick;
	logic bit_tick;
	int fail_count = 0;
	int checks_done = 0;
	logic [7:0] m_lo = 8'h01;
	logic [7:0] m_hi = 8'h00;
	logic [7:0] m_fr = 8'h00;
	int req_div = 16276;
	int req_int;
	int req_frac;

	frbg_rate_divider u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_sel(reg_sel),
		.reg_wdata(reg_wdata), .modem_control_reg(modem_control_reg),
		.divisor_low_byte(divisor_low_byte), .divisor_high_byte(divisor_high_byte),
		.divisor_fraction_and_sampling(divisor_fraction_and_sampling),
		.sample_tick(sample_tick), .bit_tick(bit_tick)
	);

	always #4 ref_clk = ~ref_clk;

	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task chk_regs;
		chk("low byte", m_lo, divisor_low_byte);
		chk("high byte", m_hi, divisor_high_byte);
		chk("fraction", m_fr, divisor_fraction_and_sampling);
	endtask : chk_regs

	// write strobe stays high across back-to-back writes; caller sits on a rising edge
	task wr(input logic [1:0] sel, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_sel <= sel;
		reg_wdata <= d;
		@(posedge ref_clk);
		if (sel == 2'h0) m_lo = d;
		if (sel == 2'h1) m_hi = d;
		if (sel == 2'h2) m_fr = d;
	endtask : wr

	// how: 0 restart only, 1 three writes, 2 three writes then a restart-only write
	task run_cfg(input int how, input logic [7:0] lo, input logic [7:0] fr, input logic pre,
		input logic [7:0] hi);
		int ratio, spb, acc, per;
		int exp_len[$];
		@(posedge ref_clk);
		modem_control_reg <= {pre, 7'($urandom)};
		if (how != 0) begin
			wr(2'h0, lo);
			wr(2'h1, hi);
			wr(2'h2, fr);
		end
		if (how != 1) wr(2'h3, 8'($urandom));
		reg_wr <= 1'b0;
		ratio = pre ? 4 : 1;
		spb = (m_fr[5:4] == 2'h1) ? 8 : (m_fr[5:4] == 2'h2) ? 4 : 16;
		acc = 0;
		// expected period lengths, built from the rules before any tick is seen
		for (int k = 0; k < 2 * spb + 1; k++) begin
			acc += m_fr[3:0];
			per = ({m_hi, m_lo} == 16'h0000) ? 65536 : {m_hi, m_lo};
			exp_len.push_back(ratio * (per + (acc >= 16 ? 1 : 0)));
			acc = acc % 16;
		end
		for (int k = 0; k < 2 * spb + 1; k++) begin
			per = exp_len.pop_front();
			for (int j = 1; j <= per; j++) begin
				@(posedge ref_clk);
				#1;
				if (k == 0 && j == 1) chk_regs();
				chk("sample tick", 8'(j == per), 8'(sample_tick));
				chk("bit tick", 8'(j == per && k % spb == spb - 1), 8'(bit_tick));
			end
		end
		$display("rate run %0d done", how);
	endtask : run_cfg

	task do_reset;
		nrst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		m_lo = 8'h01;
		m_hi = 8'h00;
		m_fr = 8'h00;
		#1;
		chk_regs();
		chk("tick in reset", 8'h00, {6'h00, sample_tick, bit_tick});
		@(posedge ref_clk);
		nrst <= 1'b1;
		$display("reset test done");
	endtask : do_reset

	initial begin
		#(8 * 60000);
		fail_count++;
		end_of_test();
	end

	initial begin
		void'($urandom(38210));
		// required divisor held in ten-thousandths: truncate the integer, round the fraction
		req_int = req_div / 10000;
		req_frac = ((req_div % 10000) * 16 + 5000) / 10000;
		do_reset();
		run_cfg(0, 8'h01, 8'h00, 1'b0, 8'h00);
		run_cfg(1, 8'h01, 8'h2f, 1'b0, 8'h00);
		run_cfg(2, 8'h03, 8'h1b, 1'b1, 8'h00);
		run_cfg(1, 8'h02, 8'h24, 1'b0, 8'h01);
		run_cfg(1, 8'(req_int), 8'h30 | 8'(req_frac), 1'b0, 8'h00);
		for (int i = 0; i < 12; i++) begin
			run_cfg(i % 3, 8'($urandom_range(6, 1)), 8'($urandom), 1'($urandom), 8'h00);
		end
		$display("rate test done");
		@(posedge ref_clk);
		do_reset();
		run_cfg(0, 8'h01, 8'h00, 1'b0, 8'h00);
		$display("second reset test done");
		end_of_test();
	end
endmodule : fractional_baud_rate_generator_bench
`default_nettype wire
